/* hdl/bldc_pkg.sv */
// constants and types for the hall commutation logic
package bldc_pkg;
  localparam int unsigned CLK_HZ            = 10_000_000;   // system clock rate
  localparam int unsigned RECHARGE_NS       = 2000;         // low-side recharge pulse, ns
  localparam int unsigned RECHARGE_CYC      = (RECHARGE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned STARTUP_MIN_US    = 1000;         // least start-up time, us
  localparam int unsigned STARTUP_CYC       = STARTUP_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned GAP_MIN_NS        = 90;           // internal least dead time, ns
  localparam int unsigned GAP_MIN_CYC       =
    ((GAP_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000) < 1 ? 1 :
    ((GAP_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  localparam int unsigned GAP_NS_PER_KOHM   = 60;           // dead time per kohm
  localparam logic [7:0]  GAP_SEL_DEFAULT   = 8'h00;        // gap_set value, 0 = pin grounded
  localparam logic [2:0]  HALL_BAD_LO       = 3'h0;         // invalid sensor code
  localparam logic [2:0]  HALL_BAD_HI       = 3'h7;         // invalid sensor code
  typedef enum logic [1:0] {PH_FLOAT, PH_LOW, PH_MOD} phase_role_t;
  typedef enum {ST_SLEEP, ST_WAIT_SUPPLY, ST_STARTUP, ST_RUN} run_state_t;
endpackage

/* hdl/gate_if.sv */
// requested half-bridge drive between commutation logic and gap inserter
`timescale 1ns/1ps
interface gate_if;
  logic hi_req;  // request upper gate on
  logic lo_req;  // request lower gate on
  logic hi_g;    // gapped upper gate
  logic lo_g;    // gapped lower gate
  modport src (output hi_req, output lo_req, input hi_g, input lo_g);
  modport gap (input hi_req, input lo_req, output hi_g, output lo_g);
endinterface

/* hdl/gap_insert.sv */
// one half-bridge dead-time inserter
`timescale 1ns/1ps
module gap_insert
  import bldc_pkg::*;
(
  input  wire logic       clk_sys,  // system clock
  input  wire logic       rst,      // sync reset, high
  input  wire logic [15:0] gap_cyc, // dead time in cycles, at least one
  gate_if.gap             g         // request in, gapped gates out
);
  logic [15:0] cnt_q;  // cycles since both gates went off
  logic        hi_q;   // upper gate register
  logic        lo_q;   // lower gate register

  // a gate turns on only after both have been off for gap_cyc cycles
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hi_q  <= 1'b0;
      lo_q  <= 1'b0;
      cnt_q <= 16'h0000;
    end else if ((hi_q && !g.hi_req) || (lo_q && !g.lo_req) || (g.hi_req && g.lo_req)) begin
      hi_q  <= 1'b0;  // turn off first, both off on conflict
      lo_q  <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (!hi_q && !lo_q) begin
      if (cnt_q < gap_cyc) begin
        cnt_q <= cnt_q + 16'h0001;
      end else begin
        hi_q <= g.hi_req;
        lo_q <= g.lo_req;
      end
    end
  end
  assign g.hi_g = hi_q;
  assign g.lo_g = lo_q;

  never_both_on_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(hi_q && lo_q)) else $error("both gates on");
  gap_before_on_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(hi_q) || $rose(lo_q) |-> $past(!hi_q && !lo_q) && $past(cnt_q) >= $past(gap_cyc))
    else $error("gate on without dead time");
endmodule

/* hdl/bldc_hall_commutation_logic.sv */
// hall-driven 120-degree commutation, start-up, sleep and fault flag
`timescale 1ns/1ps
// Notes on behaviour
// - brake low: all lower gates on
// - pwm low: driven phase held low
// - pwm high: driven phase pulled high
// - modulated follows pwm, low phase, float off
// - direction 1 sensor code table
// - direction 0 sensor code table
// - sensor edge: 2 us low pulse first
// - start after supply ok, then gate supply
// - start-up 1-2 ms, gates held off
// - after start-up drive all six gates
// - sleep low disables, ignores inputs
// - sleep release reruns start-up sequence
// - fault flag low while fault present
// - dead time between complementary gates
module bldc_hall_commutation_logic
  import bldc_pkg::*;
(
  input  wire logic       clk_sys,               // internal 10 MHz clock
  input  wire logic       rst,                   // sync reset, high
  input  wire logic       supply_ok,             // input supply above lockout level
  input  wire logic       gate_supply_ok,        // gate supply above rising level
  output logic            gate_supply_en,        // enable gate supply pump
  input  wire logic       low_power_request_low, // sleep request, low active
  input  wire logic       pwm_in,                // speed pwm
  input  wire logic       dir_in,                // rotation direction
  input  wire logic       stop_request_low,      // brake request, low active
  input  wire logic       rotor_sensor_1,        // hall a
  input  wire logic       rotor_sensor_2,        // hall b
  input  wire logic       rotor_sensor_3,        // hall c
  input  wire logic       fault_detect,          // overcurrent or overtemp present
  input  wire logic [7:0] gap_set_pin,           // dead time in kohm, 0 = grounded
  output logic [2:0]      upper_gate,            // upper gates, bit0 = phase 1
  output logic [2:0]      lower_gate,            // lower gates, bit0 = phase 1
  output logic            fault_flag_low_o,      // open-drain data, always 0
  output logic            fault_flag_low_oe,     // open-drain enable, high pulls low
  output logic            running                // start-up complete
);
  // synchronisers: 3 stages, change accepted when stage 2 and 3 agree
  localparam int unsigned NSYNC = 10;  // sensors, pwm, dir, brake, sleep, fault, two supply flags
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_q, s2_q, s3_q;
  logic [NSYNC-1:0] clean_q;   // filtered inputs
  // supply comparators are asynchronous too, so they ride the same chain
  assign raw = {supply_ok, gate_supply_ok, fault_detect, low_power_request_low,
                stop_request_low, dir_in, pwm_in,
                rotor_sensor_3, rotor_sensor_2, rotor_sensor_1};

  // three-stage input chain, stages and filtered inputs cleared to 0 on reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      clean_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NSYNC; i++) begin
        if (s2_q[i] == s3_q[i]) clean_q[i] <= s3_q[i];
      end
    end
  end

  logic [2:0] hall;       // {a,b,c} as printed order
  logic       pwm_s, dir_s, brake_n_s, sleep_n_s, fault_s;
  assign hall      = {clean_q[0], clean_q[1], clean_q[2]};
  assign pwm_s     = clean_q[3];
  assign dir_s     = clean_q[4];
  assign brake_n_s = clean_q[5];
  assign sleep_n_s = clean_q[6];
  assign fault_s   = clean_q[7];
  logic       gate_ok_s;    // filtered gate supply good
  logic       supply_ok_s;  // filtered input supply good
  assign gate_ok_s   = clean_q[8];
  assign supply_ok_s = clean_q[9];

  // start-up and sleep sequencing
  run_state_t  state_q;
  logic [15:0] start_cnt_q;   // start-up elapsed cycles
  always_ff @(posedge clk_sys) begin
    if (rst || !supply_ok_s) begin
      state_q     <= ST_SLEEP;  // undervoltage resets logic
      start_cnt_q <= 16'h0000;
    end else if (!sleep_n_s) begin
      state_q     <= ST_SLEEP;
      start_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_SLEEP: begin
          state_q <= ST_WAIT_SUPPLY;
        end
        ST_WAIT_SUPPLY: begin
          start_cnt_q <= start_cnt_q + 16'h0001;
          if (gate_ok_s) state_q <= ST_STARTUP;
        end
        ST_STARTUP: begin
          // sequence totals at least the least time, counted from wake
          if (start_cnt_q >= 16'(STARTUP_CYC)) state_q <= ST_RUN;
          else start_cnt_q <= start_cnt_q + 16'h0001;
        end
        ST_RUN: begin
          if (!gate_ok_s) state_q <= ST_WAIT_SUPPLY;  // gate supply dipped
        end
        default: state_q <= ST_SLEEP;
      endcase
    end
  end
  assign gate_supply_en = (state_q != ST_SLEEP);
  assign running        = (state_q == ST_RUN);

  // recharge pulse on any sensor transition
  logic [2:0]  hall_prev_q;
  logic [15:0] rech_cnt_q;    // remaining recharge cycles
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hall_prev_q <= 3'h0;
      rech_cnt_q  <= 16'h0000;
    end else begin
      hall_prev_q <= hall;
      if (hall != hall_prev_q) rech_cnt_q <= 16'(RECHARGE_CYC);
      else if (rech_cnt_q != 16'h0000) rech_cnt_q <= rech_cnt_q - 16'h0001;
    end
  end
  logic recharge;
  // the edge cycle itself counts, else the new phase could go high for one cycle
  assign recharge = (rech_cnt_q != 16'h0000) || (hall != hall_prev_q);

  // commutation table: role per phase
  phase_role_t role [3];
  always_comb begin
    role[0] = PH_FLOAT;
    role[1] = PH_FLOAT;
    role[2] = PH_FLOAT;
    if (dir_s) begin
      case (hall)
        3'h5: begin role[0] = PH_MOD; role[2] = PH_LOW; end
        3'h4: begin role[1] = PH_MOD; role[2] = PH_LOW; end
        3'h6: begin role[1] = PH_MOD; role[0] = PH_LOW; end
        3'h2: begin role[2] = PH_MOD; role[0] = PH_LOW; end
        3'h3: begin role[2] = PH_MOD; role[1] = PH_LOW; end
        3'h1: begin role[0] = PH_MOD; role[1] = PH_LOW; end
        default: ;
      endcase
    end else begin
      case (hall)
        3'h5: begin role[2] = PH_MOD; role[0] = PH_LOW; end
        3'h4: begin role[2] = PH_MOD; role[1] = PH_LOW; end
        3'h6: begin role[0] = PH_MOD; role[1] = PH_LOW; end
        3'h2: begin role[0] = PH_MOD; role[2] = PH_LOW; end
        3'h3: begin role[1] = PH_MOD; role[2] = PH_LOW; end
        3'h1: begin role[1] = PH_MOD; role[0] = PH_LOW; end
        default: ;
      endcase
    end
  end

  // per-phase requested gates, brake and gating on top
  logic [2:0] hi_req, lo_req;
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      hi_req[p] = 1'b0;
      lo_req[p] = 1'b0;
      if (!running || fault_s) begin
        hi_req[p] = 1'b0;
      end else if (!brake_n_s) begin
        lo_req[p] = 1'b1;
      end else if (role[p] == PH_MOD) begin
        hi_req[p] = pwm_s && !recharge;
        lo_req[p] = !pwm_s || recharge;
      end else if (role[p] == PH_LOW) begin
        lo_req[p] = 1'b1;
      end
    end
  end

  // dead time from gap pin, internal least when grounded
  // strap level read unsynchronised: change it only while the gates are off
  logic [15:0] gap_cyc;
  always_comb begin
    if (gap_set_pin == GAP_SEL_DEFAULT) gap_cyc = 16'(GAP_MIN_CYC);
    else gap_cyc = 16'(((32'(gap_set_pin) * GAP_NS_PER_KOHM) * (CLK_HZ / 1_000_000)) / 1000);
    if (gap_cyc == 16'h0000) gap_cyc = 16'h0001;
  end

  // one gap inserter per half-bridge
  for (genvar p = 0; p < 3; p++) begin : g_leg
    gate_if gi ();
    assign gi.hi_req = hi_req[p];
    assign gi.lo_req = lo_req[p];
    gap_insert u_gap (
      .clk_sys (clk_sys),
      .rst     (rst),
      .gap_cyc (gap_cyc),
      .g       (gi)
    );
    assign upper_gate[p] = gi.hi_g;
    assign lower_gate[p] = gi.lo_g;
  end

  // fault flag: only ever pulled low
  logic flt_q;
  always_ff @(posedge clk_sys) begin
    if (rst) flt_q <= 1'b0;
    else flt_q <= fault_s || (state_q == ST_RUN && !gate_ok_s);
  end
  assign fault_flag_low_o  = 1'b0;
  assign fault_flag_low_oe = flt_q;

  brake_all_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    running && !brake_n_s && !fault_s |=> upper_gate == 3'h0)
    else $error("upper gate on in brake");
  startup_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    !running |=> upper_gate == 3'h0 && lower_gate == 3'h0)
    else $error("gate on before start-up");
  sleep_stops_a: assert property (@(posedge clk_sys) disable iff (rst)
    !sleep_n_s |=> !running) else $error("running while asleep");
  recharge_len_a: assert property (@(posedge clk_sys) disable iff (rst)
    hall != hall_prev_q |=> rech_cnt_q == 16'(RECHARGE_CYC)) else $error("bad recharge");
  bad_code_float_a: assert property (@(posedge clk_sys) disable iff (rst)
    (hall == HALL_BAD_LO || hall == HALL_BAD_HI) |-> role[0] == PH_FLOAT
    && role[1] == PH_FLOAT && role[2] == PH_FLOAT) else $error("invalid code drives");
  fault_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    fault_s |=> fault_flag_low_oe) else $error("fault flag not pulled");
  supply_en_a: assert property (@(posedge clk_sys) disable iff (rst)
    running |-> gate_supply_en) else $error("run without gate supply");
  no_hi_recharge_a: assert property (@(posedge clk_sys) disable iff (rst)
    recharge |-> hi_req == 3'h0) else $error("upper request during recharge");
  run_cov: cover property (@(posedge clk_sys) $rose(running));
  brake_cov: cover property (@(posedge clk_sys) running && !brake_n_s);
  edge_cov: cover property (@(posedge clk_sys) running && hall != hall_prev_q);
endmodule

/* tb/host_model.sv */
// host controller model: sleep, pwm, direction, brake, sensors, fault pull-up
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_sys,               // system clock
  input  wire logic       fault_flag_low_o,      // open-drain data
  input  wire logic       fault_flag_low_oe,     // open-drain enable
  output logic            fault_flag_low,        // resolved flag line
  output logic            low_power_request_low, // sleep request
  output logic            pwm_in,                // speed pwm
  output logic            dir_in,                // direction
  output logic            stop_request_low,      // brake request
  output logic [2:0]      sensor_code            // sensors a,b,c
);
  // board pull-up wins whenever the device lets go of the line
  assign fault_flag_low = fault_flag_low_oe ? fault_flag_low_o : 1'b1;
  // sleep pin idles low, so the device starts asleep
  initial begin
    low_power_request_low = 1'b0;
    pwm_in = 1'b0;
    dir_in = 1'b1;
    stop_request_low = 1'b1;
    sensor_code = 3'h5;
  end
  // all levels change just after a rising edge, then hold
  task automatic drive(input logic w, input logic p, input logic d, input logic b,
                       input logic [2:0] h);
    @(posedge clk_sys);
    low_power_request_low <= w;
    pwm_in <= p;
    dir_in <= d;
    stop_request_low <= b;
    sensor_code <= h;
  endtask
endmodule

/* tb/bldc_hall_commutation_logic_tb.sv */
// self-checking bench for the hall commutation logic
`timescale 1ns/1ps
module bldc_hall_commutation_logic_tb
  import bldc_pkg::*;
  ;
  logic       clk_sys = 1'b0;        // 10 MHz
  logic       rst = 1'b1;            // sync reset
  logic       supply_ok = 1'b0;      // input supply good
  logic       gate_supply_ok = 1'b0; // gate supply good
  logic       fault_detect = 1'b0;   // fault source
  logic [7:0] gap_set_pin = 8'h00;   // grounded gap pin
  logic       gate_supply_en, running, fault_flag_low_o, fault_flag_low_oe, fault_flag_low;
  logic       low_power_request_low, pwm_in, dir_in, stop_request_low;
  logic [2:0] sensor_code, upper_gate, lower_gate;
  int         mismatches = 0;
  int         comparisons = 0;
  int         cycles = 0;
  always #50 clk_sys = ~clk_sys;
  // hang guard, well above the two start-ups plus traffic
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end
  host_model i_host_model (.clk_sys, .fault_flag_low_o, .fault_flag_low_oe, .fault_flag_low,
    .low_power_request_low, .pwm_in, .dir_in, .stop_request_low, .sensor_code);
  bldc_hall_commutation_logic i_bldc_hall_commutation_logic (.clk_sys, .rst, .supply_ok,
    .gate_supply_ok, .gate_supply_en, .low_power_request_low, .pwm_in, .dir_in,
    .stop_request_low, .rotor_sensor_1(sensor_code[2]), .rotor_sensor_2(sensor_code[1]),
    .rotor_sensor_3(sensor_code[0]), .fault_detect, .gap_set_pin, .upper_gate, .lower_gate,
    .fault_flag_low_o, .fault_flag_low_oe, .running);
  task automatic cmp_gates(input logic [5:0] got, input logic [5:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_gates({5'h00, got}, {5'h00, exp});
  endtask
  // sample on the falling edge, clear of the design's updates
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // expected {upper, lower}; invalid codes give all gates off
  function automatic logic [5:0] exp_drive(input logic d, input logic [2:0] c, input logic p);
    logic [5:0] ml;
    case ({d, c})
      4'hd: ml = 6'h0c;
      4'hc: ml = 6'h14;
      4'he: ml = 6'h11;
      4'ha: ml = 6'h21;
      4'hb: ml = 6'h22;
      4'h9: ml = 6'h0a;
      4'h5: ml = 6'h21;
      4'h4: ml = 6'h22;
      4'h6: ml = 6'h0a;
      4'h2: ml = 6'h0c;
      4'h3: ml = 6'h14;
      4'h1: ml = 6'h11;
      default: ml = 6'h00;
    endcase
    return p ? ml : {3'h0, ml[5:3] | ml[2:0]};
  endfunction
  // wake with brake low and pwm high: both must be ignored until running
  task automatic wake_up();
    int n;
    i_host_model.drive(1'b1, 1'b1, 1'b1, 1'b0, 3'h5);
    gate_supply_ok <= 1'b0;
    tick(20);
    cmp_bit(gate_supply_en, 1'b1);
    cmp_bit(running, 1'b0);
    cmp_gates({upper_gate, lower_gate}, 6'h00);
    @(posedge clk_sys);
    gate_supply_ok <= 1'b1;
    n = 21;
    while (running !== 1'b1 && n < 20000) begin
      tick(1);
      n++;
    end
    cmp_bit(n >= STARTUP_CYC && n < 20000, 1'b1);
    i_host_model.drive(1'b1, 1'b1, 1'b1, 1'b1, 3'h5);
    tick(40);
    cmp_gates({upper_gate, lower_gate}, exp_drive(1'b1, 3'h5, 1'b1));
  endtask
  // every direction, code (valid or not) and pwm level
  task automatic table_check();
    for (int d = 0; d < 2; d++) begin
      for (int c = 0; c < 8; c++) begin
        for (int p = 0; p < 2; p++) begin
          i_host_model.drive(1'b1, p[0], d[0], 1'b1, c[2:0]);
          tick(40);
          cmp_gates({upper_gate, lower_gate}, exp_drive(d[0], c[2:0], p[0]));
        end
      end
    end
  endtask
  // sensor edge with pwm held high: modulated phase first pulled low
  task automatic recharge_check();
    logic [2:0] hi_seen;
    i_host_model.drive(1'b1, 1'b1, 1'b1, 1'b1, 3'h5);
    tick(40);
    i_host_model.drive(1'b1, 1'b1, 1'b1, 1'b1, 3'h4);
    hi_seen = 3'h0;
    // phases 2 and 3 must never go high inside the recharge window
    repeat (22) begin
      tick(1);
      hi_seen = hi_seen | (upper_gate & 3'h6);
    end
    cmp_gates({hi_seen, lower_gate}, 6'h06);
    tick(RECHARGE_CYC);
    cmp_gates({upper_gate, lower_gate}, exp_drive(1'b1, 3'h4, 1'b1));
  endtask
  // brake, fault flag, then dead time on the modulated phase
  task automatic brake_fault_gap();
    int off;
    logic [2:0] ov;
    i_host_model.drive(1'b1, 1'b1, 1'b1, 1'b0, 3'h5);
    tick(10);
    cmp_gates({upper_gate, lower_gate}, 6'h07);
    i_host_model.drive(1'b1, 1'b0, 1'b1, 1'b1, 3'h5);
    fault_detect <= 1'b1;
    gap_set_pin <= 8'h0a;
    tick(10);
    cmp_bit(fault_flag_low, 1'b0);
    cmp_gates({upper_gate, lower_gate}, 6'h00);
    @(posedge clk_sys);
    fault_detect <= 1'b0;
    tick(40);
    cmp_bit(fault_flag_low, 1'b1);
    i_host_model.drive(1'b1, 1'b1, 1'b1, 1'b1, 3'h5);
    off = 0;
    ov = 3'h0;
    repeat (40) begin
      tick(1);
      ov = ov | (upper_gate & lower_gate);
      off += (upper_gate[0] === 1'b0 && lower_gate[0] === 1'b0) ? 1 : 0;
    end
    cmp_bit(off >= (10 * GAP_NS_PER_KOHM) / 100, 1'b1);
    cmp_gates({3'h0, ov}, 6'h00);
  endtask
  // sleep with brake low: everything off and ignored
  task automatic sleep_check();
    i_host_model.drive(1'b0, 1'b1, 1'b1, 1'b0, 3'h5);
    tick(10);
    cmp_bit(running, 1'b0);
    cmp_bit(gate_supply_en, 1'b0);
    cmp_gates({upper_gate, lower_gate}, 6'h00);
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    supply_ok <= 1'b1;
    wake_up();
    table_check();
    recharge_check();
    brake_fault_gap();
    sleep_check();
    wake_up();
    report_and_stop();
  end
endmodule
